// file: rtl/irqps_defines.svh
// Offsets, field positions and reset values of the interrupt pin select block.
// Assumes inclusion by the package and the design modules only.
`ifndef IRQPS_DEFINES_SVH
`define IRQPS_DEFINES_SVH

// Register byte addresses
`define IRQPS_SEL_ADDR      4'h0
`define IRQPS_PIN_ADDR      4'h4
// Select field: bit n-4 steers request n, n from 4 to 11
`define IRQPS_SEL_LSB       0
`define IRQPS_SEL_RESET     8'h00
`define IRQPS_FIRST_IRQ     4

`endif

// file: rtl/irqps_pkg.sv
// Types shared by the interrupt pin select block.
// Assumes the defines header sits beside it.
`include "irqps_defines.svh"

package irqps_pkg;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } irqps_wb_req_t;

    // Candidate pins, one pair per request 4..11
    typedef struct packed {
        logic [7:0] alt;    // Chosen when select bit is one
        logic [7:0] dflt;   // Chosen when select bit is zero
    } irqps_pins_t;

    // Whole state of the top module
    typedef struct packed {
        logic [7:0]  sel;
        logic [7:0]  irq;
        logic        ack;
        logic [31:0] dat;
    } irqps_state_t;

endpackage : irqps_pkg

// file: rtl/irqps_mux.sv
// Per-request pin multiplexer of the interrupt pin select block.
// Assumes select bits come from registers of the parent module.
`timescale 1ns/10ps

module irqps_mux
    import irqps_pkg::*;
(
    input  wire irqps_pins_t pins_in,
    input  wire logic [7:0]  sel_in,
    output logic [7:0]       irq_out
);

    // Each request takes its alternate pin when its select bit is set
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            irq_out[i] = sel_in[i] ? pins_in.alt[i] : pins_in.dflt[i];
        end
    end

endmodule : irqps_mux

// file: rtl/irqps_top.sv
// Top of the interrupt pin select block: Wishbone registers and routed requests.
// Assumes pins already synchronous to sys_clk_in and a classic Wishbone master.
//
// Operation
// - Request eleven's select bit resets to zero, zero takes port6_line3, one port2_line3.
// - Request ten's select bit resets to zero, zero takes port6_line2, one port2_line2.
// - Request nine's select bit resets to zero, zero takes port6_line1, one port2_line1.
// - Request eight's select bit resets to zero, zero takes port6_line0, one port2_line0.
// - Request seven's select bit resets to zero, zero takes port5_line7, one port_h_line3.
// - Request six's select bit resets to zero, zero takes port5_line6, one port_h_line2.
// - Request five's select bit resets to zero, zero takes port5_line5, one port8_line5.
// - Request four's select bit resets to zero, zero takes port5_line4, one an alternate pin.
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`include "irqps_defines.svh"

module irqps_top
    import irqps_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic [31:0]      wb_dat_out,
    output logic             wb_ack_out,
    input  wire logic        port6_line3_in,
    input  wire logic        port6_line2_in,
    input  wire logic        port6_line1_in,
    input  wire logic        port6_line0_in,
    input  wire logic        port5_line7_in,
    input  wire logic        port5_line6_in,
    input  wire logic        port5_line5_in,
    input  wire logic        port5_line4_in,
    input  wire logic        port2_line3_in,
    input  wire logic        port2_line2_in,
    input  wire logic        port2_line1_in,
    input  wire logic        port2_line0_in,
    input  wire logic        port_h_line3_in,
    input  wire logic        port_h_line2_in,
    input  wire logic        port8_line5_in,
    input  wire logic        irq4_alt_pin_in,
    output logic [7:0]       irq_out
);

    // Bus request, candidate pins and the registered state
    irqps_wb_req_t     req;
    wire irqps_pins_t  pins;
    irqps_state_t      state_r;
    irqps_state_t      state_nxt;
    logic [7:0]        routed;

    // Bus decode results
    logic              take;           // Request taken at this edge
    logic              sel_wr;         // Taken lane-0 write of the select register
    logic [31:0]       rd_word;        // Read data of the addressed register

    // Named select bits, one per request
    logic              irq4_pin_sel;
    logic              irq5_pin_sel;
    logic              irq6_pin_sel;
    logic              irq7_pin_sel;
    logic              irq8_pin_sel;
    logic              irq9_pin_sel;
    logic              irq10_pin_sel;
    logic              irq11_pin_sel;
    logic [7:0]        sel_vec;        // Select bits packed for the multiplexer

    // Routed request levels, one per request
    logic              irq4_routed;
    logic              irq5_routed;
    logic              irq6_routed;
    logic              irq7_routed;
    logic              irq8_routed;
    logic              irq9_routed;
    logic              irq10_routed;
    logic              irq11_routed;

    // Bundle the bus request
    assign req = '{cyc: wb_cyc_in, stb: wb_stb_in, we: wb_we_in,
                   adr: wb_adr_in, sel: wb_sel_in, dat: wb_dat_in};

    // Request four: port5_line4 while clear, its alternate pin once set
    assign pins.dflt[0]  = port5_line4_in;
    assign pins.alt[0]   = irq4_alt_pin_in;
    assign irq4_pin_sel  = state_r.sel[0];
    assign irq4_routed   = routed[0];

    // Request five: port5_line5 while clear, port8_line5 once set
    assign pins.dflt[1]  = port5_line5_in;
    assign pins.alt[1]   = port8_line5_in;
    assign irq5_pin_sel  = state_r.sel[1];
    assign irq5_routed   = routed[1];

    // Request six: port5_line6 while clear, port_h_line2 once set
    assign pins.dflt[2]  = port5_line6_in;
    assign pins.alt[2]   = port_h_line2_in;
    assign irq6_pin_sel  = state_r.sel[2];
    assign irq6_routed   = routed[2];

    // Request seven: port5_line7 while clear, port_h_line3 once set
    assign pins.dflt[3]  = port5_line7_in;
    assign pins.alt[3]   = port_h_line3_in;
    assign irq7_pin_sel  = state_r.sel[3];
    assign irq7_routed   = routed[3];

    // Request eight: port6_line0 while clear, port2_line0 once set
    assign pins.dflt[4]  = port6_line0_in;
    assign pins.alt[4]   = port2_line0_in;
    assign irq8_pin_sel  = state_r.sel[4];
    assign irq8_routed   = routed[4];

    // Request nine: port6_line1 while clear, port2_line1 once set
    assign pins.dflt[5]  = port6_line1_in;
    assign pins.alt[5]   = port2_line1_in;
    assign irq9_pin_sel  = state_r.sel[5];
    assign irq9_routed   = routed[5];

    // Request ten: port6_line2 while clear, port2_line2 once set
    assign pins.dflt[6]  = port6_line2_in;
    assign pins.alt[6]   = port2_line2_in;
    assign irq10_pin_sel = state_r.sel[6];
    assign irq10_routed  = routed[6];

    // Request eleven: port6_line3 while clear, port2_line3 once set
    assign pins.dflt[7]  = port6_line3_in;
    assign pins.alt[7]   = port2_line3_in;
    assign irq11_pin_sel = state_r.sel[7];
    assign irq11_routed  = routed[7];

    // Select bits in request order, bit 0 is request four
    assign sel_vec = {irq11_pin_sel, irq10_pin_sel, irq9_pin_sel, irq8_pin_sel,
                      irq7_pin_sel,  irq6_pin_sel,  irq5_pin_sel, irq4_pin_sel};

    // Route each request through its select bit
    irqps_mux u_mux (
        .pins_in (pins),
        .sel_in  (sel_vec),
        .irq_out (routed)
    );

    // Strobe with no ack pending: the edge that takes a request
    function automatic logic bus_take(input irqps_wb_req_t r, input logic ack_pend);
        bus_take = r.cyc && r.stb && !ack_pend;
    endfunction : bus_take

    // Write that carries lane 0 to the select register
    function automatic logic sel_write(input irqps_wb_req_t r);
        sel_write = r.we && r.sel[0] && (r.adr == `IRQPS_SEL_ADDR);
    endfunction : sel_write

    // Read data for a register address
    function automatic logic [31:0] rd_mux(input logic [3:0] adr, input logic [7:0] sel,
                                           input logic [7:0] irq);
        unique case (adr)
            `IRQPS_SEL_ADDR: rd_mux = {24'h000000, sel};
            `IRQPS_PIN_ADDR: rd_mux = {24'h000000, irq};
            default:         rd_mux = 32'h00000000;   // Unmapped reads zero
        endcase
    endfunction : rd_mux

    // Bus decode of the current request
    assign take    = bus_take(req, state_r.ack);
    assign sel_wr  = take && sel_write(req);
    assign rd_word = rd_mux(req.adr, state_r.sel, state_r.irq);

    // Next state: one-cycle ack, byte-lane write of the select field
    always_comb begin
        state_nxt        = state_r;
        state_nxt.ack    = take;                               // Ack one cycle after the take
        // Routed levels, one cycle behind the pins
        state_nxt.irq[0] = irq4_routed;
        state_nxt.irq[1] = irq5_routed;
        state_nxt.irq[2] = irq6_routed;
        state_nxt.irq[3] = irq7_routed;
        state_nxt.irq[4] = irq8_routed;
        state_nxt.irq[5] = irq9_routed;
        state_nxt.irq[6] = irq10_routed;
        state_nxt.irq[7] = irq11_routed;
        if (take) begin
            state_nxt.dat = rd_word;                           // Read data stands with ack
        end
        if (sel_wr) begin
            state_nxt.sel = req.dat[`IRQPS_SEL_LSB +: 8];
        end
    end

    // State register; select bits clear so default pins are routed
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r.sel <= `IRQPS_SEL_RESET;
            state_r.irq <= 8'h00;
            state_r.ack <= 1'b0;
            state_r.dat <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign wb_ack_out = state_r.ack;
    assign wb_dat_out = state_r.dat;
    assign irq_out    = state_r.irq;

endmodule : irqps_top

// file: test/irqps_assertions.sv
// Checker: each routed request against its chosen pin, one cycle late.
// Assumes a bind to irqps_top; select bits are shadowed from Wishbone writes.
`timescale 1ns/10ps
module irqps_assertions (
    input wire logic sys_clk_in, rstn_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out,
    input wire logic [3:0]  wb_adr_in, wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic port6_line3_in, port6_line2_in, port6_line1_in, port6_line0_in,
    input wire logic port5_line7_in, port5_line6_in, port5_line5_in, port5_line4_in,
    input wire logic port2_line3_in, port2_line2_in, port2_line1_in, port2_line0_in,
    input wire logic port_h_line3_in, port_h_line2_in, port8_line5_in, irq4_alt_pin_in,
    input wire logic [7:0]  irq_out
);
    logic [7:0] sh_r, d, a, e;
    logic       up_r;
    // Pin pictures and the expected route
    assign d = {port6_line3_in, port6_line2_in, port6_line1_in, port6_line0_in,
                port5_line7_in, port5_line6_in, port5_line5_in, port5_line4_in};
    assign a = {port2_line3_in, port2_line2_in, port2_line1_in, port2_line0_in,
                port_h_line3_in, port_h_line2_in, port8_line5_in, irq4_alt_pin_in};
    assign e = (sh_r & a) | (~sh_r & d);
    // Shadow of the select byte, loaded where a lane-0 write is taken
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            {up_r, sh_r} <= 9'h000;
        end else begin
            up_r <= 1'b1;
            if (wb_cyc_in && wb_stb_in && !wb_ack_out && wb_we_in && wb_adr_in == 4'h0
                && wb_sel_in[0]) sh_r <= wb_dat_in[7:0];
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in || !up_r);
    property p_r11; irq_out[7] == $past(e[7]); endproperty
    a_r11: assert property (p_r11) else $error("irq11 route wrong");
    property p_r10; irq_out[6] == $past(e[6]); endproperty
    a_r10: assert property (p_r10) else $error("irq10 route wrong");
    property p_r9; irq_out[5] == $past(e[5]); endproperty
    a_r9: assert property (p_r9) else $error("irq9 route wrong");
    property p_r8; irq_out[4] == $past(e[4]); endproperty
    a_r8: assert property (p_r8) else $error("irq8 route wrong");
    property p_r7; irq_out[3] == $past(e[3]); endproperty
    a_r7: assert property (p_r7) else $error("irq7 route wrong");
    property p_r6; irq_out[2] == $past(e[2]); endproperty
    a_r6: assert property (p_r6) else $error("irq6 route wrong");
    property p_r5; irq_out[1] == $past(e[1]); endproperty
    a_r5: assert property (p_r5) else $error("irq5 route wrong");
    property p_r4; irq_out[0] == $past(e[0]); endproperty
    a_r4: assert property (p_r4) else $error("irq4 route wrong");
    property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held past one cycle");
    property p_ack_take; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
    a_ack_take: assert property (p_ack_take) else $error("taken request not acked");
endmodule : irqps_assertions

// file: test/irqps_pin_model.sv
// Far-side pins: candidate levels for requests 4..11.
// Assumes the bench gives the wanted picture; levels change after an edge.
`timescale 1ns/10ps
module irqps_pin_model
    import irqps_pkg::*;
(
    input  wire logic [15:0] pat_in,
    input  wire logic        sys_clk_in,
    output irqps_pins_t      pins_out
);
    // Synchronous sources, registered on the clock
    always_ff @(posedge sys_clk_in) pins_out <= pat_in;
endmodule : irqps_pin_model

// file: test/testbench.sv
// Testbench: pin routing of irqps_top under Wishbone control.
// Assumes the pin model and checker are compiled before it.
`timescale 1ns/10ps
module testbench;
    import irqps_pkg::*;
    logic        sys_clk_in = 1'b0, rstn_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0, bs = 4'h0;
    logic [31:0] wd = 32'h0, q;
    logic [7:0]  al = 8'h00, df = 8'h00;
    wire  [31:0] rd;
    wire  [7:0]  irq;
    wire         ack;
    wire  irqps_pins_t p;
    int          error_cnt = 0, check_count = 0;
    always #10 sys_clk_in = ~sys_clk_in;
    irqps_pin_model u_pins (.pat_in({al, df}), .sys_clk_in(sys_clk_in), .pins_out(p));
    irqps_top u_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(bs), .wb_dat_in(wd),
        .wb_dat_out(rd), .wb_ack_out(ack), .irq_out(irq),
        .port6_line3_in(p.dflt[7]), .port6_line2_in(p.dflt[6]), .port6_line1_in(p.dflt[5]),
        .port6_line0_in(p.dflt[4]), .port5_line7_in(p.dflt[3]), .port5_line6_in(p.dflt[2]),
        .port5_line5_in(p.dflt[1]), .port5_line4_in(p.dflt[0]), .port2_line3_in(p.alt[7]),
        .port2_line2_in(p.alt[6]), .port2_line1_in(p.alt[5]), .port2_line0_in(p.alt[4]),
        .port_h_line3_in(p.alt[3]), .port_h_line2_in(p.alt[2]),
        .port8_line5_in(p.alt[1]), .irq4_alt_pin_in(p.alt[0]));
    // Classic Wishbone cycle, held until ack is seen
    task automatic wb(input logic w, input logic [3:0] ad, s, input logic [31:0] dt);
        {cyc, stb, we, adr, bs, wd} <= {2'h3, w, ad, s, dt};
        do @(posedge sys_clk_in); while (ack !== 1'b1);
        q = rd;
        {cyc, stb} <= 2'h0;
        @(posedge sys_clk_in);
    endtask : wb
    task automatic chk(input logic [31:0] g, x);
        check_count++;
        if (g !== x) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk
    // Pin picture in, routed requests compared two stages later
    task automatic pin_chk(input logic [7:0] a, f, s);
        {al, df} <= {a, f};
        repeat (3) @(posedge sys_clk_in);
        chk(irq, (s & a) | (~s & f));
    endtask : pin_chk
    // Reset value, default routing, unmapped read
    task automatic t_reset();
        wb(1'b0, 4'h0, 4'hF, 32'h0);
        chk(q, 32'h0);
        pin_chk(8'h00, 8'hFF, 8'h00);
        wb(1'b0, 4'h4, 4'hF, 32'h0);
        chk(q, 32'hFF);
        pin_chk(8'hFF, 8'h00, 8'h00);
        wb(1'b0, 4'h8, 4'hF, 32'h0);
        chk(q, 32'h0);
    endtask : t_reset
    // Each select bit alone, both pin pictures
    task automatic t_route();
        for (int k = 0; k < 8; k++) begin
            wb(1'b1, 4'h0, 4'h1, 32'h1 << k);
            wb(1'b0, 4'h0, 4'hF, 32'h0);
            chk(q, 32'h1 << k);
            pin_chk(8'hFF, 8'h00, 8'h01 << k);
            pin_chk(8'h00, 8'hFF, 8'h01 << k);
        end
    endtask : t_route
    // Lane 0 off is ignored; upper bytes never store
    task automatic t_refuse();
        wb(1'b1, 4'h0, 4'hE, 32'hFF);
        wb(1'b0, 4'h0, 4'hF, 32'h0);
        chk(q, 32'h80);
        pin_chk(8'hFF, 8'h00, 8'h80);
        wb(1'b1, 4'h0, 4'h1, 32'hFFFFFF00);
        wb(1'b0, 4'h0, 4'hF, 32'h0);
        chk(q, 32'h0);
        pin_chk(8'hFF, 8'h00, 8'h00);
    endtask : t_refuse
    // Reset in mid-run clears a set select field
    task automatic t_rerst();
        wb(1'b1, 4'h0, 4'h1, 32'hFF);
        wb(1'b0, 4'h0, 4'hF, 32'h0);
        chk(q, 32'hFF);
        rstn_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        @(posedge sys_clk_in);
        wb(1'b0, 4'h0, 4'hF, 32'h0);
        chk(q, 32'h0);
        pin_chk(8'hFF, 8'h00, 8'h00);
    endtask : t_rerst
    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    // Main sequence after 16 cycles of reset
    initial begin
        repeat (16) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        @(posedge sys_clk_in);
        t_reset();
        t_route();
        t_refuse();
        t_rerst();
        report_and_stop();
    end
    // Watchdog
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
endmodule : testbench
bind irqps_top irqps_assertions u_chk (.*);
